/* File: core/dcc_pkg.sv */
// Constants, register map and carrier types for the doubler clock control.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package dcc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SYNC_INPUTS = 4;

  // Byte addresses
  localparam logic [31:0] OFS_CTRL1 = 32'h0000_0010;
  localparam logic [31:0] OFS_CTRL2 = 32'h0000_0014;
  localparam logic [31:0] OFS_CLAMP = 32'h0000_0018;
  localparam logic [31:0] OFS_STATUS = 32'h0000_001C;

  // Control 1 fields
  localparam int unsigned C1_POL = 0;
  localparam int unsigned C1_RSVD = 1;
  localparam int unsigned C1_EN = 2;
  localparam int unsigned C1_PINSEL = 3;
  // Clamp register fields
  localparam int unsigned CL_DET_EN = 0;
  localparam int unsigned CL_THR = 1;
  // Status fields
  localparam int unsigned ST_LEVEL = 0;
  localparam int unsigned ST_ABOVE = 1;
  localparam int unsigned ST_RUN = 2;

  // Sync input slots
  localparam int unsigned SI_PULSE = 0;
  localparam int unsigned SI_SLOW = 1;
  localparam int unsigned SI_FAST = 2;
  localparam int unsigned SI_PSC = 3;

  // Clock select codes
  localparam logic [3:0] SEL_STOP = 4'h0;
  localparam logic [3:0] SEL_PULSE = 4'h1;
  localparam logic [3:0] SEL_SLOW = 4'h2;
  localparam logic [3:0] SEL_PSC2 = 4'h3;
  localparam logic [3:0] SEL_PSC4 = 4'h4;
  localparam logic [3:0] SEL_PSC8 = 4'h5;
  localparam logic [3:0] SEL_PSC16 = 4'h6;
  localparam logic [3:0] SEL_PSC32 = 4'h7;
  localparam logic [3:0] SEL_FAST1 = 4'h8;
  localparam logic [3:0] SEL_FAST2 = 4'h9;
  localparam logic [3:0] SEL_FAST4 = 4'hA;
  localparam logic [3:0] SEL_DIV3 = 4'hB;
  localparam logic [3:0] SEL_PSC6 = 4'hC;
  localparam logic [3:0] SEL_PSC12 = 4'hD;
  localparam logic [3:0] SEL_PSC24 = 4'hE;
  localparam logic [3:0] SEL_PSC48 = 4'hF;

  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [1:0] DIV3_FIRST = 2'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dcc_apb_req_t;

  typedef struct packed {
    logic [3:0] clk_sel;
    logic output_polarity;
    logic enable;
    logic pin_sel;
    logic det_en;
    logic thr_sel;
  } dcc_ctrl_t;

  localparam dcc_ctrl_t CTRL_RESET = '0;
endpackage

/* File: core/dcc_top.sv */
// Doubler clock control: select, divide, clamp gating and pin steering.
// Assumes async clock pins sampled at 250 MHz and an analog comparator flag.
// Notes on behaviour
// - Code zero stops the clock; output rests low, or high/HZ with polarity set.
// - Code one routes the pulse counter pin; software enables that function.
// - Code two passes the low-speed crystal clock straight through.
// - Codes 3-7 divide prescaler by 2..32; codes C-F by 6..48.
// - Codes 8, 9, A give fast oscillator /1, /2, /4; software enables it.
// - Code B divides prescaler by three, high:low two to one, reversed by polarity.
// - Divided sources except divide-by-three have equal high and low time; codes 1, 2, 8 keep the input's duty.
// - Doubler runs only while enabled; pin select picks open-drain or CMOS pin.
// - With clamping, clock runs below threshold and stops above it.
// - Threshold has two levels; detection works only when detect enable is one.
// - Control port is channel four, data port five, written by group one writes.
// - System reset clears every control bit.
// - Pins taken by the doubler or clamp ignore general-purpose data and direction.
// - Synthesizer off puts both phase comparator outputs in high impedance.
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire dcc_apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Clock sources, asynchronous
  input wire logic pulse_count_input,
  input wire logic slow_osc_clk,
  input wire logic fast_osc_freq,
  input wire logic prescaler_input,
  // Clamp comparator
  input wire logic clamp_sense_above,
  output logic clamp_detect_enable,
  output logic clamp_thresh_high,
  // General-purpose port requests for shared pins
  input wire logic gp_od_data,
  input wire logic gp_od_dir,
  input wire logic gp_cmos_data,
  input wire logic gp_cmos_dir,
  input wire logic gp_sense_data,
  input wire logic gp_sense_dir,
  // Doubler pins
  output logic doubler_opendrain_out,
  output logic doubler_opendrain_oe,
  output logic doubler_cmos_out,
  output logic doubler_cmos_oe,
  output logic sense_pin_out,
  output logic sense_pin_oe,
  // Phase comparator outputs
  input wire logic synth_off,
  input wire logic [1:0] phase_cmp_data,
  input wire logic [1:0] phase_cmp_drive,
  output logic [1:0] phase_cmp_outputs,
  output logic [1:0] phase_cmp_oe
);

  // Synchronisers: stage 0 is read only by stage 1
  wire logic [SYNC_INPUTS-1:0] async_in;
  logic [SYNC_INPUTS-1:0] sync_q [SYNC_STAGES];
  logic [SYNC_INPUTS-1:0] prev_q;
  logic [SYNC_INPUTS-1:0] sync_out;
  logic [SYNC_INPUTS-1:0] rise;
  logic above_m_q;
  logic above_q;

  assign async_in = {prescaler_input, fast_osc_freq, slow_osc_clk, pulse_count_input};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_INPUTS; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          sync_q[0][gi] <= 1'b0;
          sync_q[1][gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          sync_q[0][gi] <= async_in[gi];
          sync_q[1][gi] <= sync_q[0][gi];
          prev_q[gi] <= sync_q[1][gi];
        end
      end
      assign sync_out[gi] = sync_q[1][gi];
      assign rise[gi] = sync_q[1][gi] & ~prev_q[gi];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      above_m_q <= 1'b0;
      above_q <= 1'b0;
    end else begin
      above_m_q <= clamp_sense_above;
      above_q <= above_m_q;
    end
  end

  // Register file
  dcc_ctrl_t ctrl_q;
  dcc_ctrl_t ctrl_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic lvl_q;
  logic lvl_d;

  wire logic access = apb_req.psel & apb_req.penable;
  // Writes land only at the completing edge, never in the wait cycle
  wire logic wr = access & pready & apb_req.pwrite;
  wire logic rd = access & ~apb_req.pwrite;
  wire logic hit_c1 = apb_req.paddr == OFS_CTRL1;
  wire logic hit_c2 = apb_req.paddr == OFS_CTRL2;
  wire logic hit_cl = apb_req.paddr == OFS_CLAMP;
  wire logic hit_st = apb_req.paddr == OFS_STATUS;
  wire logic hit_any = hit_c1 | hit_c2 | hit_cl | hit_st;
  wire logic running;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && hit_c1) begin
      ctrl_d.output_polarity = apb_req.pwdata[C1_POL];
      ctrl_d.enable = apb_req.pwdata[C1_EN];
      ctrl_d.pin_sel = apb_req.pwdata[C1_PINSEL];
    end
    if (wr && hit_c2) begin
      ctrl_d.clk_sel = apb_req.pwdata[3:0];
    end
    if (wr && hit_cl) begin
      ctrl_d.det_en = apb_req.pwdata[CL_DET_EN];
      ctrl_d.thr_sel = apb_req.pwdata[CL_THR];
    end
  end

  // Bit one of control 1 is not stored and reads zero
  always_comb begin
    prdata_d = prdata_q;
    if (rd) begin
      prdata_d = '0;
      if (hit_c1) begin
        prdata_d[C1_POL] = ctrl_q.output_polarity;
        prdata_d[C1_EN] = ctrl_q.enable;
        prdata_d[C1_PINSEL] = ctrl_q.pin_sel;
      end
      if (hit_c2) begin
        prdata_d[3:0] = ctrl_q.clk_sel;
      end
      if (hit_cl) begin
        prdata_d[CL_DET_EN] = ctrl_q.det_en;
        prdata_d[CL_THR] = ctrl_q.thr_sel;
      end
      if (hit_st) begin
        prdata_d[ST_LEVEL] = lvl_q;
        prdata_d[ST_ABOVE] = above_q;
        prdata_d[ST_RUN] = running;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pslverr_q <= access & ~hit_any;
    end
  end

  // One-wait slave: read data and error appear the cycle after the access
  // phase starts, so pready is withheld for exactly one access cycle.
  logic wait_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= access & ~wait_q;
    end
  end
  wire logic take = access & wait_q;
  assign pready = wait_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Dividers on synchronised source edges
  logic [4:0] psc_bin_q;
  logic [1:0] div3_q;
  logic [3:0] div6_q;
  logic [1:0] fast_bin_q;
  wire logic div3_wrap = rise[SI_PSC] & (div3_q == DIV3_LAST);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      psc_bin_q <= '0;
      div3_q <= DIV3_FIRST;
      div6_q <= '0;
      fast_bin_q <= '0;
    end else begin
      if (rise[SI_PSC]) begin
        psc_bin_q <= psc_bin_q + 5'h01;
        div3_q <= div3_wrap ? DIV3_FIRST : div3_q + 2'h1;
      end
      if (div3_wrap) begin
        div6_q <= div6_q + 4'h1;
      end
      if (rise[SI_FAST]) begin
        fast_bin_q <= fast_bin_q + 2'h1;
      end
    end
  end

  // Source select; binary counter bits are all square waves
  function automatic logic pick_source(input logic [3:0] sel, input logic [SYNC_INPUTS-1:0] s,
                                       input logic [4:0] pb, input logic [1:0] d3,
                                       input logic [3:0] d6, input logic [1:0] fb);
    logic r;
    r = 1'b0;
    unique case (sel)
      SEL_STOP: r = 1'b0;
      SEL_PULSE: r = s[SI_PULSE];
      SEL_SLOW: r = s[SI_SLOW];
      SEL_PSC2: r = pb[0];
      SEL_PSC4: r = pb[1];
      SEL_PSC8: r = pb[2];
      SEL_PSC16: r = pb[3];
      SEL_PSC32: r = pb[4];
      SEL_FAST1: r = s[SI_FAST];
      SEL_FAST2: r = fb[0];
      SEL_FAST4: r = fb[1];
      SEL_DIV3: r = (d3 != DIV3_LAST);
      SEL_PSC6: r = d6[0];
      SEL_PSC12: r = d6[1];
      SEL_PSC24: r = d6[2];
      SEL_PSC48: r = d6[3];
    endcase
    return r;
  endfunction

  wire logic raw = pick_source(ctrl_q.clk_sel, sync_out, psc_bin_q, div3_q, div6_q, fast_bin_q);
  wire logic clamp_hold = ctrl_q.det_en & above_q;
  assign running = ctrl_q.enable & ~clamp_hold;

  // Stopped level equals polarity: low with 0, high or released with 1
  assign lvl_d = running ? (raw ^ ctrl_q.output_polarity) : ctrl_q.output_polarity;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // Pin steering; a pin owned by the doubler drops its port request
  wire logic od_own = ctrl_q.enable & ~ctrl_q.pin_sel;
  wire logic cmos_own = ctrl_q.enable & ctrl_q.pin_sel;
  assign doubler_opendrain_out = od_own ? 1'b0 : gp_od_data;
  assign doubler_opendrain_oe = od_own ? ~lvl_q : gp_od_dir;
  assign doubler_cmos_out = cmos_own ? lvl_q : gp_cmos_data;
  assign doubler_cmos_oe = cmos_own | gp_cmos_dir;
  // Comparator needs the sense pin released while detecting
  assign sense_pin_out = ctrl_q.det_en ? 1'b0 : gp_sense_data;
  assign sense_pin_oe = ctrl_q.det_en ? 1'b0 : gp_sense_dir;
  assign clamp_detect_enable = ctrl_q.det_en;
  assign clamp_thresh_high = ctrl_q.thr_sel;

  // Phase comparator float in synthesizer off
  assign phase_cmp_outputs = phase_cmp_data;
  assign phase_cmp_oe = synth_off ? 2'h0 : phase_cmp_drive;

  // Checks
  sequence wr_sel_s;
    take && apb_req.pwrite && hit_c2;
  endsequence

  property sel_write_p;
    @(posedge clock) disable iff (!rst_b)
      wr_sel_s |=> (ctrl_q.clk_sel == $past(apb_req.pwdata[3:0]));
  endproperty
  sel_write_a: assert property (sel_write_p) else $error("clock select not taken");

  stop_rest_a: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrl_q.clk_sel == SEL_STOP) |=> (lvl_q == $past(ctrl_q.output_polarity)))
    else $error("stopped clock not at rest level");

  off_rest_a: assert property (@(posedge clock) disable iff (!rst_b)
    !ctrl_q.enable [*2] |-> (lvl_q == $past(ctrl_q.output_polarity)))
    else $error("disabled doubler toggles");

  clamp_stop_a: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrl_q.det_en && above_q) |=> (lvl_q == $past(ctrl_q.output_polarity)))
    else $error("clamp did not stop clock");

  slow_pass_a: assert property (@(posedge clock) disable iff (!rst_b)
    (running && ctrl_q.clk_sel == SEL_SLOW) |=> (lvl_q == $past(sync_out[SI_SLOW] ^ ctrl_q.output_polarity)))
    else $error("slow clock not passed");

  sequence div3_low_s;
    (div3_q == DIV3_LAST) ##1 (div3_q == DIV3_LAST);
  endsequence

  div3_step_a: assert property (@(posedge clock) disable iff (!rst_b)
    div3_wrap |=> (div3_q == DIV3_FIRST))
    else $error("divide by three did not wrap");

  cmos_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
    cmos_own |-> (doubler_cmos_oe && doubler_cmos_out == lvl_q))
    else $error("cmos pin not carrying doubler");

  od_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
    od_own |-> (!doubler_opendrain_out && doubler_opendrain_oe == !lvl_q))
    else $error("open-drain pin not carrying doubler");

  phase_hz_a: assert property (@(posedge clock) disable iff (!rst_b)
    synth_off |-> (phase_cmp_oe == 2'h0))
    else $error("phase outputs driven in synth off");

  fast_half_a: assert property (@(posedge clock) disable iff (!rst_b)
    rise[SI_FAST] |=> (fast_bin_q == $past(fast_bin_q) + 2'h1))
    else $error("fast divider missed an edge");

endmodule

/* File: dv/dcc_coil_model.sv */
// Behavioural coil, diode and filter network pumped by the CMOS doubler pin.
// Assumes the bench clock; the divided voltage is compared against two levels.
module dcc_coil_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Doubler pin and threshold select
  input wire logic pump_out,
  input wire logic pump_oe,
  input wire logic thresh_high,
  // Comparator flag
  output logic above
);
  timeunit 1ns;
  timeprecision 1ps;
  int volt_q;
  int leak_q;
  logic pump_d1;
  wire logic pump = pump_out & pump_oe;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      volt_q <= 0;
      leak_q <= 0;
      pump_d1 <= 1'b0;
      above <= 1'b0;
    end else begin
      pump_d1 <= pump;
      leak_q <= leak_q + 1;
      // Charge per pump edge, slow leak so clamping settles into bursts
      if (pump && !pump_d1 && volt_q < 40) begin
        volt_q <= volt_q + 1;
      end else if (leak_q % 64 == 0 && volt_q > 0) begin
        volt_q <= volt_q - 1;
      end
      above <= volt_q > (thresh_high ? 24 : 16);
    end
  end
endmodule

/* File: dv/dcc_tb.sv */
// Self-checking bench: APB register calls, clock sources and pin checks.
// Assumes the coil model on the CMOS pin and sources slower than clock/2.
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[FAIL] %0t ns: got %0h expected %0h", $time, got, exp); \
  end \
end
module testbench
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  dcc_apb_req_t apb_req = '0;
  logic pready, pslverr, clamp_sense_above, clamp_detect_enable, clamp_thresh_high;
  logic [31:0] prdata;
  logic pulse_count_input = 1'b0, slow_osc_clk = 1'b0, fast_osc_freq = 1'b0, prescaler_input = 1'b0;
  logic gp_od_data = 1'b0, gp_od_dir = 1'b0, gp_cmos_data = 1'b0, gp_cmos_dir = 1'b0;
  logic gp_sense_data = 1'b0, gp_sense_dir = 1'b0, synth_off = 1'b0;
  logic doubler_opendrain_out, doubler_opendrain_oe, doubler_cmos_out, doubler_cmos_oe;
  logic sense_pin_out, sense_pin_oe;
  logic [1:0] phase_cmp_data = 2'h0, phase_cmp_drive = 2'h0, phase_cmp_outputs, phase_cmp_oe;
  int failures = 0, tests_run = 0, src_n = 0, abv_n = 0, det_n = 0, clamped_n = 0;
  int hi_t [16] = '{0, 6, 10, 8, 16, 32, 64, 128, 3, 6, 12, 8, 24, 48, 96, 192};

  dcc_top u_dut (.clock(clock), .rst_b(rst_b), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .pulse_count_input(pulse_count_input), .slow_osc_clk(slow_osc_clk),
    .fast_osc_freq(fast_osc_freq), .prescaler_input(prescaler_input), .clamp_sense_above(clamp_sense_above),
    .clamp_detect_enable(clamp_detect_enable), .clamp_thresh_high(clamp_thresh_high), .gp_od_data(gp_od_data),
    .gp_od_dir(gp_od_dir), .gp_cmos_data(gp_cmos_data), .gp_cmos_dir(gp_cmos_dir),
    .gp_sense_data(gp_sense_data), .gp_sense_dir(gp_sense_dir), .doubler_opendrain_out(doubler_opendrain_out),
    .doubler_opendrain_oe(doubler_opendrain_oe), .doubler_cmos_out(doubler_cmos_out),
    .doubler_cmos_oe(doubler_cmos_oe), .sense_pin_out(sense_pin_out), .sense_pin_oe(sense_pin_oe),
    .synth_off(synth_off), .phase_cmp_data(phase_cmp_data), .phase_cmp_drive(phase_cmp_drive),
    .phase_cmp_outputs(phase_cmp_outputs), .phase_cmp_oe(phase_cmp_oe));
  dcc_coil_model u_coil (.clock(clock), .rst_b(rst_b), .pump_out(doubler_cmos_out), .pump_oe(doubler_cmos_oe),
    .thresh_high(clamp_thresh_high), .above(clamp_sense_above));

  initial begin
    forever #2 clock = ~clock;
  end
  // Sources synchronous to the bench clock so measured phases are exact
  always @(posedge clock) begin
    src_n <= src_n + 1;
    prescaler_input <= (src_n % 8) < 4;
    fast_osc_freq <= (src_n % 6) < 3;
    pulse_count_input <= (src_n % 12) < 6;
    slow_osc_clk <= (src_n % 20) < 10;
  end
  // Clamped output must rest at the polarity level (bench uses polarity 1)
  always @(negedge clock) begin
    if (clamp_sense_above === 1'b1) abv_n++;
    else abv_n = 0;
    if (clamp_detect_enable === 1'b1) det_n++;
    else det_n = 0;
    if (det_n >= 3 && abv_n >= 5) begin
      clamped_n++;
      `CHK(doubler_cmos_out, 1'b1)
    end
  end

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    r = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  task automatic wt(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (doubler_cmos_out !== v && n < 500);
    if (n >= 500) failures++;
  endtask
  // Two edge pairs skip the short first period after a code switch
  task automatic meas(input int h, input int l);
    int n;
    int m;
    wt(1'b0);
    wt(1'b1);
    wt(1'b0);
    wt(1'b1);
    n = 0;
    m = 0;
    while (doubler_cmos_out === 1'b1 && n < 500) begin
      @(negedge clock);
      n++;
    end
    while (doubler_cmos_out === 1'b0 && m < 500) begin
      @(negedge clock);
      m++;
    end
    `CHK(n, h)
    `CHK(m, l)
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    rdc(OFS_CTRL1, 32'h0000_0000, 1'b0);
    rdc(OFS_CTRL2, 32'h0000_0000, 1'b0);
    rdc(OFS_CLAMP, 32'h0000_0000, 1'b0);
    rdc(32'h0000_0020, 32'h0000_0000, 1'b1);
    // CMOS pin with polarity set, reserved bit kept at zero
    wr(OFS_CTRL1, 32'h0000_000D);
    rdc(OFS_CTRL1, 32'h0000_000D, 1'b0);
    @(negedge clock);
    `CHK({doubler_cmos_out, doubler_cmos_oe}, 2'h3)
    rdc(OFS_STATUS, 32'h0000_0005, 1'b0);
    for (int c = 1; c < 16; c++) begin
      wr(OFS_CTRL2, 32'(c));
      meas(hi_t[c], (c == 11) ? 16 : hi_t[c]);
    end
    wr(OFS_CTRL2, 32'h0000_0000);
    wr(OFS_CTRL1, 32'h0000_0004);
    gp_od_data <= 1'b1;
    repeat (4) @(negedge clock);
    `CHK({doubler_opendrain_out, doubler_opendrain_oe}, 2'h1)
    wr(OFS_CTRL1, 32'h0000_0000);
    gp_cmos_data <= 1'b1;
    repeat (4) @(negedge clock);
    `CHK({doubler_opendrain_out, doubler_cmos_out}, 2'h3)
    @(posedge clock);
    gp_cmos_data <= 1'b0;
    gp_sense_data <= 1'b1;
    gp_sense_dir <= 1'b1;
    wr(OFS_CTRL1, 32'h0000_000D);
    wr(OFS_CTRL2, 32'h0000_0003);
    wr(OFS_CLAMP, 32'h0000_0001);
    @(negedge clock);
    `CHK({clamp_detect_enable, clamp_thresh_high, sense_pin_oe}, 3'h4)
    repeat (2500) @(posedge clock);
    `CHK(clamped_n > 0, 1'b1)
    wr(OFS_CLAMP, 32'h0000_0003);
    @(negedge clock);
    `CHK(clamp_thresh_high, 1'b1)
    repeat (1500) @(posedge clock);
    wr(OFS_CLAMP, 32'h0000_0000);
    repeat (1500) @(posedge clock);
    `CHK({clamp_sense_above, sense_pin_oe, sense_pin_out}, 3'h7)
    meas(8, 8);
    @(posedge clock);
    synth_off <= 1'b1;
    phase_cmp_drive <= 2'h3;
    phase_cmp_data <= 2'h2;
    @(negedge clock);
    `CHK({phase_cmp_oe, phase_cmp_outputs}, 4'h2)
    @(posedge clock);
    synth_off <= 1'b0;
    phase_cmp_data <= 2'h0;
    @(negedge clock);
    `CHK(phase_cmp_oe, 2'h3)
    `CHK(phase_cmp_outputs, 2'h0)
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    rdc(OFS_CTRL1, 32'h0000_0000, 1'b0);
    rdc(OFS_CTRL2, 32'h0000_0000, 1'b0);
    complete_run();
  end
endmodule
